// file: src/uixc_defs.svh
`ifndef UIXC_DEFS_SVH
`define UIXC_DEFS_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define UIXC_ADDR_COUNT 4'h0
`define UIXC_ADDR_CFG 4'h4
`define UIXC_ADDR_STAT 4'h8
`define UIXC_ADDR_BITS 4

// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define UIXC_EMPTY_BIT 7
`define UIXC_CNT_MSB 6
`define UIXC_CNT_W 7
`define UIXC_CNT_RST 7'h00
`define UIXC_EMPTY_RST 1'b0
`define UIXC_CFG_ISO_BIT 0
`define UIXC_CFG_ISO_RST 1'b0
`define UIXC_STAT_SENT_BIT 0
`define UIXC_STAT_NACK_BIT 1
`define UIXC_STAT_EMPTY_BIT 2

// ------------------------------------------------------------
// bus answers
// ------------------------------------------------------------
`define UIXC_RESP_OKAY 2'b00
`define UIXC_RESP_SLVERR 2'b10

`endif

// file: src/uixc_pkg.sv
package uixc_pkg;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {UIXC_HS_NONE, UIXC_HS_DATA, UIXC_HS_NACK} uixc_hs_e;
    typedef logic [7:0] uixc_byte_t;
endpackage

// file: src/uixc_regif.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// carrier between bus slave and endpoint byte
// ------------------------------------------------------------
interface uixc_regif;
    logic wr_count;
    logic [7:0] wdata;
    logic [7:0] count_byte;
    modport host (output wr_count, output wdata, input count_byte);
    modport dev (input wr_count, input wdata, output count_byte);
endinterface

// file: src/uixc_count_byte.sv
`timescale 1ns/1ps
`include "uixc_defs.svh"
// ------------------------------------------------------------
// endpoint x count and empty flag byte
// ------------------------------------------------------------
module uixc_count_byte
    import uixc_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset
    input wire logic in_ok, // successful in transaction
    uixc_regif.dev rif // register side
);
    logic empty_r;
    logic [`UIXC_CNT_MSB:0] cnt_r;

    // flag: hardware set beats software clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            empty_r <= `UIXC_EMPTY_RST;
        else if (in_ok)
            empty_r <= 1'b1;
        else if (rif.wr_count)
            empty_r <= rif.wdata[`UIXC_EMPTY_BIT];
    end

    // count written by software only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= `UIXC_CNT_RST;
        else if (rif.wr_count)
            cnt_r <= rif.wdata[`UIXC_CNT_MSB:0];
    end

    assign rif.count_byte = {empty_r, cnt_r};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_flag_set_done: assert property (@(posedge aclk) disable iff (!aresetn)
        in_ok |=> rif.count_byte[`UIXC_EMPTY_BIT])
        else $error("empty flag not set after in transaction");
    a_count_write_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        rif.wr_count |=> rif.count_byte[`UIXC_CNT_MSB:0] == $past(rif.wdata[`UIXC_CNT_MSB:0]))
        else $error("count not stored");
endmodule

// file: src/uixc_top.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "uixc_defs.svh"
// Functional notes
// - successful in transaction sets the x buffer empty flag, bit 7
// - non-isochronous endpoint with flag set answers every in with nack
// - isochronous endpoint never nacks and ignores the flag
// - bits 6 to 0 hold a seven-bit software-writable data count
module uixc_top
    import uixc_pkg::*;
(
    input wire logic aclk, // clock, 40 MHz
    input wire logic aresetn, // sync reset
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic in_token, // in token to this endpoint
    input wire logic in_ack, // host acked data, transaction good
    output logic hs_data, // send data packet, pulse
    output logic hs_nack // send nack, pulse
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic aw_hold_r;
    logic w_hold_r;
    logic [3:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wlane0_r;
    logic iso_r;
    logic sent_r;
    logic nacked_r;
    logic wr_go;
    uixc_hs_e hs_nxt;
    uixc_regif rif ();

    // ------------------------------------------------------------
    // endpoint byte
    // ------------------------------------------------------------
    uixc_count_byte u_byte (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_ok(in_ack),
        .rif(rif.dev)
    );

    // exact word match; the whole offset must agree, no aliasing
    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] k);
        addr_is = (a == k);
    endfunction

    // ------------------------------------------------------------
    // write channel: address and data in either order
    // ------------------------------------------------------------
    // address half, kept until the write lands
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_r <= 1'b0;
            awaddr_r <= 4'h0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_hold_r <= 1'b0;
    end

    // data half; only byte lane 0 carries the endpoint byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_r <= 1'b0;
            wbyte_r <= 8'h00;
            wlane0_r <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wlane0_r <= s_axi_wstrb[0];
        end
        else if (wr_go)
            w_hold_r <= 1'b0;
    end

    // readiness: one write at a time, refused while a response waits
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !wr_go;
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !wr_go;
        end
    end

    // a write lands once both halves are held and no answer is pending
    assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign rif.wr_count = wr_go && wlane0_r && addr_is(awaddr_r, `UIXC_ADDR_COUNT);
    assign rif.wdata = wbyte_r;

    // write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UIXC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (addr_is(awaddr_r, `UIXC_ADDR_COUNT) || addr_is(awaddr_r, `UIXC_ADDR_CFG)
                || addr_is(awaddr_r, `UIXC_ADDR_STAT)) ? `UIXC_RESP_OKAY : `UIXC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // endpoint type; isochronous changes the handshake policy
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            iso_r <= `UIXC_CFG_ISO_RST;
        else if (wr_go && wlane0_r && addr_is(awaddr_r, `UIXC_ADDR_CFG))
            iso_r <= wbyte_r[`UIXC_CFG_ISO_BIT];
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // one read at a time; arready returns one cycle after the answer is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UIXC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `UIXC_RESP_OKAY;
            if (addr_is(s_axi_araddr, `UIXC_ADDR_COUNT))
                s_axi_rdata <= {24'h00_0000, rif.count_byte};
            else if (addr_is(s_axi_araddr, `UIXC_ADDR_CFG))
                s_axi_rdata <= {31'h0000_0000, iso_r};
            else if (addr_is(s_axi_araddr, `UIXC_ADDR_STAT))
                s_axi_rdata <= {29'h0000_0000, rif.count_byte[`UIXC_EMPTY_BIT], nacked_r, sent_r};
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `UIXC_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ------------------------------------------------------------
    // handshake decision for each in token
    // ------------------------------------------------------------
    always_comb
    begin
        hs_nxt = UIXC_HS_NONE;
        if (in_token)
        begin
            if (!iso_r && rif.count_byte[`UIXC_EMPTY_BIT])
                hs_nxt = UIXC_HS_NACK;
            else
                hs_nxt = UIXC_HS_DATA;
        end
    end

    // registered so each answer is a clean one-cycle pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hs_data <= 1'b0;
            hs_nack <= 1'b0;
        end
        else
        begin
            hs_data <= (hs_nxt == UIXC_HS_DATA);
            hs_nack <= (hs_nxt == UIXC_HS_NACK);
        end
    end

    // sticky status, cleared by writing one; new event wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sent_r <= 1'b0;
            nacked_r <= 1'b0;
        end
        else
        begin
            if (hs_nxt == UIXC_HS_DATA)
                sent_r <= 1'b1;
            else if (wr_go && wlane0_r && addr_is(awaddr_r, `UIXC_ADDR_STAT) && wbyte_r[`UIXC_STAT_SENT_BIT])
                sent_r <= 1'b0;
            if (hs_nxt == UIXC_HS_NACK)
                nacked_r <= 1'b1;
            else if (wr_go && wlane0_r && addr_is(awaddr_r, `UIXC_ADDR_STAT) && wbyte_r[`UIXC_STAT_NACK_BIT])
                nacked_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_nack_when_empty: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_token && !iso_r && rif.count_byte[`UIXC_EMPTY_BIT]) |=> hs_nack && !hs_data)
        else $error("empty endpoint did not nack");
    a_iso_never_nack: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_token && iso_r) |=> hs_data && !hs_nack)
        else $error("isochronous endpoint nacked");
    a_data_when_full: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_token && !rif.count_byte[`UIXC_EMPTY_BIT]) |=> hs_data)
        else $error("loaded endpoint sent no data");
    a_clear_flag_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (rif.wr_count && !rif.wdata[`UIXC_EMPTY_BIT] && !in_ack) |=> !rif.count_byte[`UIXC_EMPTY_BIT])
        else $error("flag clear lost");
    a_bresp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_answers: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");

    // ------------------------------------------------------------
    // further bus and link checks
    // ------------------------------------------------------------
    // a token gets one answer, never both
    a_hs_one_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        !(hs_data && hs_nack))
        else $error("data and nack together");
    // no answer unless a token came the cycle before
    a_hs_needs_token: assert property (@(posedge aclk) disable iff (!aresetn)
        !in_token |=> !hs_data && !hs_nack)
        else $error("handshake without token");
    // each nack leaves its sticky mark
    a_nack_mark_set: assert property (@(posedge aclk) disable iff (!aresetn)
        hs_nack |-> nacked_r)
        else $error("nack not recorded");
    // each data answer leaves its sticky mark
    a_sent_mark_set: assert property (@(posedge aclk) disable iff (!aresetn)
        hs_data |-> sent_r)
        else $error("data answer not recorded");
    // write halves refused while a response waits
    a_resp_blocks_write: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    // a write lands exactly once
    a_write_lands_once: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> !wr_go)
        else $error("write applied twice");
    // upper read lanes are always zero
    a_read_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    // config write sets the endpoint type
    a_iso_cfg_kept: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && wlane0_r && addr_is(awaddr_r, `UIXC_ADDR_CFG))
        |=> iso_r == $past(wbyte_r[`UIXC_CFG_ISO_BIT]))
        else $error("endpoint type not stored");
    // status read shows the flag as it stood when the read was taken
    a_stat_flag_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, `UIXC_ADDR_STAT))
        |=> s_axi_rdata[`UIXC_STAT_EMPTY_BIT] == $past(rif.count_byte[`UIXC_EMPTY_BIT]))
        else $error("status flag copy wrong");
endmodule

// file: bench/uixc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side seen through the buffer manager
// ----------------------------------------
module uixc_host_model (
    input wire logic aclk, // clock
    output logic in_token, // token to endpoint
    output logic in_ack, // transaction good
    input wire logic hs_data, // data packet sent
    input wire logic hs_nack // nack sent
);
    initial
    begin
        in_token = 1'b0;
        in_ack = 1'b0;
    end
    // one in transaction; only a data packet can be acked, a nack ends it
    task automatic in_xfer(input logic ack_en, output logic [1:0] seen);
        @(posedge aclk);
        in_token <= 1'b1;
        @(posedge aclk);
        in_token <= 1'b0;
        #1 seen = {hs_nack, hs_data};
        if (ack_en && seen == 2'b01)
        begin
            @(posedge aclk);
            in_ack <= 1'b1;
            @(posedge aclk);
            in_ack <= 1'b0;
        end
    endtask
endmodule

// file: bench/tb_usb_in_ep_x_count_nack.sv
`timescale 1ns/1ps
`include "uixc_defs.svh"
module tb_usb_in_ep_x_count_nack;
    import uixc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, seen, resp;
    logic in_token, in_ack, hs_data, hs_nack;
    logic [31:0] rd;
    int mismatches = 0, cmp_count = 0;
    always #12.5 aclk = ~aclk;
    uixc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .in_token(in_token), .in_ack(in_ack), .hs_data(hs_data), .hs_nack(hs_nack));
    uixc_host_model host_u (.aclk(aclk), .in_token(in_token), .in_ack(in_ack), .hs_data(hs_data),
        .hs_nack(hs_nack));
    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // address and data offered together, each dropped once its own ready is seen
    task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (s_axi_awready && !ad)
            begin
                ad = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd)
            begin
                wd = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    // watchdog at 5000 cycles, well past the hundred or so cycles the tests need
    initial
    begin
        #(25 * 5000);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values and an unmapped place
        for (int i = 0; i < 3; i++)
        begin
            axi_rd(4'(4 * i), rd, resp);
            chk("reset value", rd, 32'h0000_0000);
        end
        axi_rd(4'hc, rd, resp);
        chk("unmapped read resp", 32'(resp), 32'(`UIXC_RESP_SLVERR));
        axi_wr(4'hc, 8'h11, resp);
        chk("unmapped write resp", 32'(resp), 32'(`UIXC_RESP_SLVERR));
        $display("test reset done");
        // count field read back, extreme and mid values
        axi_wr(`UIXC_ADDR_COUNT, 8'h7f, resp);
        chk("count write resp", 32'(resp), 32'(`UIXC_RESP_OKAY));
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("count 7f", rd, 32'h0000_007f);
        axi_wr(`UIXC_ADDR_COUNT, 8'h2a, resp);
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("count 2a", rd, 32'h0000_002a);
        $display("test count done");
        // bulk endpoint: data, empty flag set, nack until software clears
        host_u.in_xfer(1'b1, seen);
        chk("first in", 32'(seen), 32'h0000_0001);
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("flag after in", rd, 32'h0000_00aa);
        host_u.in_xfer(1'b1, seen);
        chk("nack 1", 32'(seen), 32'h0000_0002);
        host_u.in_xfer(1'b0, seen);
        chk("nack 2", 32'(seen), 32'h0000_0002);
        axi_rd(`UIXC_ADDR_STAT, rd, resp);
        chk("status", rd, 32'h0000_0007);
        axi_wr(`UIXC_ADDR_STAT, 8'h03, resp);
        axi_rd(`UIXC_ADDR_STAT, rd, resp);
        chk("status cleared", rd, 32'h0000_0004);
        axi_wr(`UIXC_ADDR_COUNT, 8'h05, resp);
        host_u.in_xfer(1'b0, seen);
        chk("data after clear", 32'(seen), 32'h0000_0001);
        $display("test bulk done");
        // isochronous endpoint: flag set but never a nack
        axi_wr(`UIXC_ADDR_CFG, 8'h01, resp);
        host_u.in_xfer(1'b1, seen);
        chk("iso first", 32'(seen), 32'h0000_0001);
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("iso flag", rd, 32'h0000_0085);
        host_u.in_xfer(1'b0, seen);
        chk("iso ignores flag", 32'(seen), 32'h0000_0001);
        axi_wr(`UIXC_ADDR_COUNT, 8'h10, resp);
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("iso cleared", rd, 32'h0000_0010);
        s_axi_wstrb <= 4'h0;
        axi_wr(`UIXC_ADDR_COUNT, 8'h55, resp);
        s_axi_wstrb <= 4'hf;
        axi_rd(`UIXC_ADDR_COUNT, rd, resp);
        chk("lane off ignored", rd, 32'h0000_0010);
        $display("test iso done");
        print_verdict();
    end
endmodule
